// [qss_defs.svh]
// constants for the queued serial slave: widths, reset values, timing counts
`ifndef QSS_DEFS_SVH
`define QSS_DEFS_SVH
`define QSS_PTR_W         4
`define QSS_WORD_W        16
`define QSS_LEN_W         5
`define QSS_LEN_MAX       5'h10
`define QSS_LEN_DEFAULT   5'h08
`define QSS_LEN_CODE_16   4'h0
`define QSS_LEN_CODE_8    4'h8
`define QSS_PTR_RESET     4'h0
`define QSS_WRAP_ZERO     4'h0
`define QSS_CLK_PERIOD_NS 4
`define QSS_GAP_NS        600
`define QSS_GAP_CYCLES    ((`QSS_GAP_NS + `QSS_CLK_PERIOD_NS - 1) / `QSS_CLK_PERIOD_NS)
`define QSS_FIFO_DEPTH    8
`endif

// [qss_pkg.sv]
// types shared by the queued serial slave
package qss_pkg;
  typedef enum logic [3:0] {
    QSS_IDLE  = 4'h1,
    QSS_LOAD  = 4'h2,
    QSS_SHIFT = 4'h4,
    QSS_STORE = 4'h8
  } qss_state_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] data;
  } qss_rx_entry_type;
endpackage

// [qss_slave.sv]
// queued serial slave: receive fifo and the slave-mode queue engine
`include "qss_defs.svh"

module qss_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = `QSS_FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("qss_fifo: depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // full and empty are exact: no slot is held back
  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
endmodule // qss_fifo

module qss_slave
  import qss_pkg::*;
#(
  parameter int FIFO_DEPTH = `QSS_FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        sck_in,
  input  wire logic        ss_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  input  wire logic        master_select_in,
  input  wire logic        ss_is_output_in,
  input  wire logic        cpol_in,
  input  wire logic        cpha_in,
  input  wire logic [3:0]  transfer_length_in,
  input  wire logic        wrap_enable_in,
  input  wire logic        wrap_target_in,
  input  wire logic [3:0]  end_queue_pointer_in,
  input  wire logic        nqp_wr_in,
  input  wire logic [3:0]  nqp_in,
  input  wire logic        spe_wr_in,
  input  wire logic        spe_in,
  input  wire logic        queue_done_irq_enable_in,
  input  wire logic        halt_fault_irq_enable_in,
  input  wire logic        status_rd_in,
  input  wire logic        status_wr_in,
  input  wire logic        status_done_in,
  input  wire logic        status_fault_in,
  input  wire logic        tx_wr_in,
  input  wire logic [3:0]  tx_addr_in,
  input  wire logic [15:0] tx_data_in,
  input  wire logic        rx_rd_in,
  input  wire logic [3:0]  rx_addr_in,
  output logic [15:0]      rx_data_out,
  output logic             spi_enable_out,
  output logic             queue_done_flag_out,
  output logic             mode_fault_flag_out,
  output logic [3:0]       completed_queue_pointer_out,
  output logic             pins_to_gpio_out,
  output logic             irq_out
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("qss_slave: fifo depth too small");
    end
  end

  function automatic logic [4:0] qss_len(input logic [3:0] code);
    if (code == `QSS_LEN_CODE_16) begin
      qss_len = `QSS_LEN_MAX;
    end else if (code < `QSS_LEN_CODE_8) begin
      qss_len = `QSS_LEN_DEFAULT;
    end else begin
      qss_len = {1'b0, code};
    end
  endfunction

  logic [15:0]      tx_ram [16];
  logic [15:0]      rx_ram [16];
  logic [2:0]       s1;
  logic [2:0]       s2;
  logic [2:0]       s3;
  logic [2:0]       f;
  logic [2:0]       f_d;
  qss_state_type    state;
  logic [3:0]       wp;
  logic [3:0]       nqp;
  logic             nqp_pend;
  logic [4:0]       bit_cnt;
  logic [15:0]      tx_sh;
  logic [15:0]      rx_sh;
  logic             done_rd;
  logic             fault_rd;
  logic             irq_arm;
  logic [4:0]       len;
  logic             sck_edge;
  logic             lead_edge;
  logic             sample_edge;
  logic             drive_edge;
  logic             selected;
  logic             start;
  logic             fault_cond;
  logic             at_end;
  logic             store_go;
  logic             fifo_ready;
  logic             drain_valid;
  qss_rx_entry_type push_entry;
  qss_rx_entry_type drain_entry;

  // three stages; the filtered level moves only when stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1  <= 3'h2;
      s2  <= 3'h2;
      s3  <= 3'h2;
      f   <= 3'h2;
      f_d <= 3'h2;
    end else begin
      s1  <= {sck_in, ss_n_in, mosi_in};
      s2  <= s1;
      s3  <= s2;
      f   <= ((s2 ~^ s3) & s2) | ((s2 ^ s3) & f);
      f_d <= f;
    end
  end

  assign len         = qss_len(transfer_length_in);
  assign selected    = !f[1];
  assign sck_edge    = f[2] ^ f_d[2];
  assign lead_edge   = sck_edge && (f[2] != cpol_in);
  assign sample_edge = cpha_in ? (sck_edge && !lead_edge) : lead_edge;
  assign drive_edge  = cpha_in ? lead_edge : (sck_edge && !lead_edge);
  assign start       = (state == QSS_IDLE) && selected && spi_enable_out && !master_select_in;
  assign fault_cond  = master_select_in && spi_enable_out && !ss_is_output_in && selected;
  assign at_end      = (wp == end_queue_pointer_in);
  assign store_go    = (state == QSS_STORE) && fifo_ready;
  assign push_entry  = '{addr: wp, data: rx_sh & ~(16'hffff << len)};

  always_ff @(posedge clk_in) begin
    if (tx_wr_in) begin
      tx_ram[tx_addr_in] <= tx_data_in;
    end
    if (drain_valid && !rx_rd_in) begin
      rx_ram[drain_entry.addr] <= drain_entry.data;
    end
  end

  // software reads take the ram port, so a busy reader back-pressures the fifo
  qss_fifo #(
    .WIDTH ($bits(qss_rx_entry_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (state == QSS_STORE),
    .in_ready_out  (fifo_ready),
    .in_data_in    (push_entry),
    .out_valid_out (drain_valid),
    .out_ready_in  (!rx_rd_in),
    .out_data_out  (drain_entry)
  );

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_data_out <= 16'h0000;
    end else if (rx_rd_in) begin
      rx_data_out <= rx_ram[rx_addr_in];
    end
  end

  // queue engine; command ram, divider and delays do not exist here
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state                       <= QSS_IDLE;
      wp                          <= `QSS_PTR_RESET;
      bit_cnt                     <= 5'h00;
      tx_sh                       <= 16'h0000;
      rx_sh                       <= 16'h0000;
      completed_queue_pointer_out <= `QSS_PTR_RESET;
    end else begin
      case (state)
        QSS_IDLE: begin
          if (start) begin
            if (bit_cnt == 5'h00) begin
              if (nqp_pend) begin
                wp <= nqp;
              end
              state <= QSS_LOAD;
            end else begin
              state <= QSS_SHIFT;
            end
          end
        end
        QSS_LOAD: begin
          tx_sh   <= tx_ram[wp] << (5'h10 - len);
          bit_cnt <= 5'h00;
          state   <= QSS_SHIFT;
        end
        QSS_SHIFT: begin
          if (drive_edge && bit_cnt != 5'h00) begin
            tx_sh <= {tx_sh[14:0], 1'b0};
          end
          if (!selected || !spi_enable_out || master_select_in) begin
            state <= QSS_IDLE;
          end else if (sample_edge) begin
            rx_sh   <= {rx_sh[14:0], f[0]};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt + 5'h01 == len) begin
              state <= QSS_STORE;
            end
          end
        end
        QSS_STORE: begin
          if (fifo_ready) begin
            completed_queue_pointer_out <= wp;
            bit_cnt                     <= 5'h00;
            if (!at_end) begin
              wp    <= wp + 4'h1;
              state <= QSS_LOAD;
            end else if (wrap_enable_in) begin
              wp    <= wrap_target_in ? nqp : `QSS_WRAP_ZERO;
              state <= QSS_LOAD;
            end else begin
              state <= QSS_IDLE;
            end
          end
        end
        default: begin
          state <= QSS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nqp      <= `QSS_PTR_RESET;
      nqp_pend <= 1'b1;
    end else begin
      if (nqp_wr_in) begin
        nqp <= nqp_in;
      end
      if (nqp_wr_in || (spe_wr_in && spe_in && !spi_enable_out)) begin
        nqp_pend <= 1'b1;
      end else if (start && bit_cnt == 5'h00) begin
        nqp_pend <= 1'b0;
      end
    end
  end

  // enable: software sets it; hardware clears it on stop or fault
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spi_enable_out   <= 1'b0;
      pins_to_gpio_out <= 1'b0;
    end else begin
      if (fault_cond) begin
        spi_enable_out   <= 1'b0;
        pins_to_gpio_out <= 1'b1;
      end else if (store_go && at_end && !wrap_enable_in) begin
        spi_enable_out <= 1'b0;
      end else if (spe_wr_in) begin
        spi_enable_out <= spe_in;
        if (spe_in) begin
          pins_to_gpio_out <= 1'b0;
        end
      end
    end
  end

  // read-then-write clearing; a set in the same cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      queue_done_flag_out <= 1'b0;
      mode_fault_flag_out <= 1'b0;
      done_rd             <= 1'b0;
      fault_rd            <= 1'b0;
      irq_arm             <= 1'b0;
    end else begin
      if (status_rd_in) begin
        done_rd  <= queue_done_flag_out;
        fault_rd <= mode_fault_flag_out;
      end else if (status_wr_in) begin
        done_rd  <= 1'b0;
        fault_rd <= 1'b0;
      end
      if (store_go && at_end) begin
        queue_done_flag_out <= 1'b1;
        irq_arm             <= queue_done_irq_enable_in;
      end else if (status_wr_in && done_rd && !status_done_in) begin
        queue_done_flag_out <= 1'b0;
      end
      if (fault_cond) begin
        mode_fault_flag_out <= 1'b1;
      end else if (status_wr_in && fault_rd && !status_fault_in) begin
        mode_fault_flag_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out     <= 1'b0;
      miso_out    <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      irq_out     <= (queue_done_flag_out && irq_arm) ||
                     (mode_fault_flag_out && halt_fault_irq_enable_in);
      miso_out    <= tx_sh[15];
      miso_oe_out <= selected && spi_enable_out && !master_select_in;
    end
  end

  chk_master_no_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (master_select_in && $past(master_select_in)) |-> !miso_oe_out)
    else $error("miso driven in master mode");
  chk_start_new_ptr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (start && bit_cnt == 5'h00 && nqp_pend) |=> (wp == $past(nqp)) && (state == QSS_LOAD))
    else $error("select did not start at new pointer");
  chk_store_cpt: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (store_go && !at_end) |=> (completed_queue_pointer_out == $past(wp)) && (wp == $past(wp) + 4'h1)
    ##1 (state == QSS_SHIFT))
    else $error("store order wrong");
  chk_len_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state == QSS_SHIFT) |-> (bit_cnt < len) && (len <= `QSS_LEN_MAX) && (len >= `QSS_LEN_DEFAULT))
    else $error("bit count beyond length");
  chk_end_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (store_go && at_end && !wrap_enable_in && !fault_cond) |=>
    queue_done_flag_out && !spi_enable_out && (state == QSS_IDLE) ##1 (state == QSS_IDLE)[*3])
    else $error("queue end without stop");
  chk_wrap_target: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (store_go && at_end && wrap_enable_in && !fault_cond && !spe_wr_in) |=> queue_done_flag_out &&
    spi_enable_out && (wp == ($past(wrap_target_in) ? $past(nqp) : `QSS_WRAP_ZERO)))
    else $error("wrap went to wrong address");
  chk_irq_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (queue_done_flag_out && irq_arm) |=> irq_out)
    else $error("queue done request dropped");
  chk_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(queue_done_flag_out) |-> $past(status_wr_in) && $past(done_rd) && !$past(status_done_in))
    else $error("done flag cleared without read then write");
  chk_mode_fault: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fault_cond |=> mode_fault_flag_out && !spi_enable_out && pins_to_gpio_out)
    else $error("mode fault not taken");
  chk_no_fault_out: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ss_is_output_in && !mode_fault_flag_out) |=> !mode_fault_flag_out)
    else $error("mode fault with select as output");
endmodule // qss_slave

// [qss_spi_master.sv]
// behavioural bus master facing the queued serial slave
module qss_spi_master #(
  parameter int HALF_NS = 80,
  parameter int GAP_NS  = 600
) (
  output logic      sck_out,
  output logic      ss_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  input  wire logic cpol_in,
  input  wire logic cpha_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sck_out  = 1'b0;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  task automatic sel(input logic v);
    ss_n_out = v;
    // released data line must not keep its last bit
    mosi_out = ~mosi_out;
  endtask

  // n bits of w, msb first; keep leaves the slave selected afterwards
  task automatic xfer(input int n, input logic [15:0] w, input bit keep, output logic [15:0] r);
    r = '0;
    sck_out = cpol_in;
    if (ss_n_out) begin
      ss_n_out = 1'b0;
      #(2*HALF_NS);
    end
    for (int i = n - 1; i >= 0; i--) begin
      if (cpha_in) sck_out = ~cpol_in;
      mosi_out = w[i];
      #HALF_NS;
      sck_out = cpha_in ? cpol_in : ~cpol_in;
      // undriven miso reads as the pull-up level
      r = {r[14:0], miso_oe_in ? miso_in : 1'b1};
      #HALF_NS;
      if (!cpha_in) sck_out = cpol_in;
    end
    if (!keep) sel(1'b1);
    #GAP_NS;
  endtask
endmodule // qss_spi_master

// [qss_tb.sv]
// self-checking bench for the queued serial slave and its fifo
module testbench;
  import qss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in, rst_n_in, sck_in, ss_n_in, mosi_in, miso_out, miso_oe_out;
  logic master_select_in, ss_is_output_in, cpol_in, cpha_in, wrap_enable_in, wrap_target_in;
  logic nqp_wr_in, spe_wr_in, spe_in, queue_done_irq_enable_in, halt_fault_irq_enable_in;
  logic status_rd_in, status_wr_in, status_done_in, status_fault_in, tx_wr_in, rx_rd_in;
  logic spi_enable_out, queue_done_flag_out, mode_fault_flag_out, pins_to_gpio_out, irq_out;
  logic [3:0]  transfer_length_in, end_queue_pointer_in, nqp_in, tx_addr_in, rx_addr_in;
  logic [3:0]  completed_queue_pointer_out;
  logic [15:0] tx_data_in, rx_data_out, r;
  logic        rd_d, xdone;
  int          k;
  logic [15:0] tx [16];
  logic [15:0] rw [8];
  logic [15:0] expq [$];
  int          fail_count = 0;
  int          n_compared = 0;

  qss_slave dut (.*);
  qss_spi_master mdl (.sck_out(sck_in), .ss_n_out(ss_n_in), .mosi_out(mosi_in), .miso_in(miso_out),
                      .miso_oe_in(miso_oe_out), .cpol_in(cpol_in), .cpha_in(cpha_in));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // k: 0 tx ram, 1 new pointer, 2 enable, 3 status read, 4 status write, 5 rx read
  task automatic wr(input int k, input logic [15:0] d, input logic [3:0] a);
    @(negedge clk_in);
    case (k)
      0: begin tx_wr_in = 1'b1; tx_addr_in = a; tx_data_in = d; end
      1: begin nqp_wr_in = 1'b1; nqp_in = a; end
      2: begin spe_wr_in = 1'b1; spe_in = d[0]; end
      3: status_rd_in = 1'b1;
      4: begin status_wr_in = 1'b1; {status_done_in, status_fault_in} = d[1:0]; end
      default: begin rx_rd_in = 1'b1; rx_addr_in = a; expq.push_back(d); end
    endcase
    @(negedge clk_in);
    {tx_wr_in, nqp_wr_in, spe_wr_in, status_rd_in, status_wr_in, rx_rd_in} = '0;
  endtask

  task automatic clear_flags();
    wr(3, 0, 0);
    wr(4, 0, 0);
    @(negedge clk_in);
  endtask

  task automatic x8(input int i, input bit keep, input logic [3:0] cqp);
    mdl.xfer(8, rw[i], keep, r);
    chk(completed_queue_pointer_out, cqp);
  endtask

  // read data is compared one clock after the read was taken
  always @(posedge clk_in) begin
    if (rd_d) chk(rx_data_out, expq.pop_front());
    rd_d <= rx_rd_in;
  end

  initial begin
    {master_select_in, ss_is_output_in, cpol_in, cpha_in, wrap_enable_in, wrap_target_in} = '0;
    {nqp_wr_in, spe_wr_in, spe_in, queue_done_irq_enable_in, halt_fault_irq_enable_in} = '0;
    {status_rd_in, status_wr_in, status_done_in, status_fault_in, tx_wr_in, rx_rd_in} = '0;
    {transfer_length_in, end_queue_pointer_in, nqp_in, tx_addr_in, rx_addr_in, tx_data_in} = '0;
    void'($urandom(32'h48ec48e4));
    rst_n_in = 1'b0;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in) rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk({spi_enable_out, queue_done_flag_out, mode_fault_flag_out, irq_out, miso_oe_out}, 0);
    for (int i = 0; i < 16; i++) begin
      tx[i] = 16'($urandom);
      wr(0, tx[i], 4'(i));
    end
    foreach (rw[i]) rw[i] = 16'($urandom);
    // 16-bit words 0..2, no wrap, done irq enabled
    end_queue_pointer_in = 4'h2;
    queue_done_irq_enable_in = 1'b1;
    wr(2, 1, 0);
    for (int i = 0; i < 3; i++) begin
      mdl.xfer(16, rw[i], 0, r);
      chk(r, tx[i]);
      chk(completed_queue_pointer_out, 4'(i));
    end
    for (int k = 0; k < 200 && queue_done_flag_out !== 1'b1; k++) @(negedge clk_in);
    chk({spi_enable_out, queue_done_flag_out, irq_out}, 3'b011);
    mdl.xfer(16, rw[3], 0, r);
    chk(r, 16'hffff);
    chk(completed_queue_pointer_out, 4'h2);
    for (int i = 0; i < 3; i++) wr(5, rw[i], 4'(i));
    wr(4, 0, 0);
    queue_done_irq_enable_in = 1'b0;
    @(negedge clk_in);
    chk({queue_done_flag_out, irq_out}, 2'b11);
    clear_flags();
    chk({queue_done_flag_out, irq_out}, 2'b00);
    // reserved length code, mode 3, wrap to address zero, then to the new pointer
    {transfer_length_in, cpol_in, cpha_in, wrap_enable_in} = {4'h3, 3'b111};
    end_queue_pointer_in = 4'h6;
    wr(1, 0, 4'h5);
    wr(2, 1, 0);
    x8(0, 0, 4'h5);
    mdl.xfer(4, rw[1], 0, r);
    mdl.xfer(4, rw[2], 0, r);
    chk({completed_queue_pointer_out, spi_enable_out, queue_done_flag_out}, 6'h1b);
    x8(3, 1, 4'h0);
    x8(4, 0, 4'h1);
    wr(5, {8'h00, rw[0][7:0]}, 4'h5);
    wr(5, {8'h00, rw[1][3:0], rw[2][3:0]}, 4'h6);
    wr(5, {8'h00, rw[3][7:0]}, 4'h0);
    wr(5, {8'h00, rw[4][7:0]}, 4'h1);
    clear_flags();
    wrap_target_in = 1'b1;
    end_queue_pointer_in = 4'h9;
    wr(1, 0, 4'h8);
    x8(5, 0, 4'h8);
    x8(6, 0, 4'h9);
    chk(queue_done_flag_out, 1'b1);
    x8(7, 0, 4'h8);
    clear_flags();
    // master mode: select pin as output, then as input
    {master_select_in, ss_is_output_in, halt_fault_irq_enable_in} = 3'b111;
    mdl.sel(1'b0);
    repeat (10) @(negedge clk_in);
    chk({mode_fault_flag_out, miso_oe_out, spi_enable_out}, 3'b001);
    ss_is_output_in = 1'b0;
    repeat (10) @(negedge clk_in);
    chk({mode_fault_flag_out, spi_enable_out, pins_to_gpio_out, irq_out}, 4'b1011);
    mdl.sel(1'b1);
    repeat (10) @(negedge clk_in);
    clear_flags();
    wr(2, 1, 0);
    chk({mode_fault_flag_out, spi_enable_out, pins_to_gpio_out, irq_out}, 4'b0100);
    // receive fifo: reads hold the ram port while eight words queue up, then drain
    {master_select_in, transfer_length_in, end_queue_pointer_in, wrap_target_in} = {1'b0, 4'h8, 4'hf, 1'b0};
    wr(1, 0, 4'h0);
    xdone = 1'b0;
    fork
      begin
        for (int i = 0; i < 8; i++) x8(i, 0, 4'(i));
        xdone = 1'b1;
      end
      for (k = 0; k < 8000 && !xdone; k++) begin
        @(negedge clk_in) {rx_rd_in, rx_addr_in} = {1'b1, 4'h9};
        expq.push_back({8'h00, rw[6][7:0]});
      end
    join
    chk({15'h0000, k < 8000}, 16'h0001);
    @(negedge clk_in) rx_rd_in = 1'b0;
    repeat (12) @(negedge clk_in);
    for (int i = 0; i < 8; i++) wr(5, {8'h00, rw[i][7:0]}, 4'(i));
    repeat (4) @(negedge clk_in);
    chk(16'(expq.size()), 16'h0000);
    repeat (4) @(negedge clk_in);
    stop_test();
  end
endmodule // testbench
